// ==== rtl/bge_entry.sv ====
`timescale 1ns/10ps
// Background entry instruction handling inside the core.
module bge_entry
    import bge_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic insn_valid,
    input wire logic [15:0] insn_word,
    input wire logic [31:0] insn_pc,
    input wire logic [15:0] psw_in,
    input wire logic [31:0] ssp_in,
    input wire logic [31:0] vbr_in,
    input wire logic bg_enable,
    input wire logic bg_exit,
    input wire logic [31:0] bg_pc_in,
    input wire logic wr_ready,
    input wire logic vec_valid,
    input wire logic [31:0] vec_data,
    input wire logic [3:0] trace_raddr,
    output logic busy,
    output logic freeze,
    output logic resume,
    output logic new_pc_valid,
    output logic [31:0] new_pc,
    output logic [31:0] ssp_out,
    output logic [15:0] psw_out,
    output bge_wr_t wr,
    output logic vec_req,
    output logic [31:0] vec_addr,
    output logic [31:0] trace_rdata
);
    bge_regs_t r_reg;
    bge_regs_t r_next;
    logic [3:0] wptr_reg;
    logic hit;
    logic [31:0] frame_word;

    // Exact match only; the instruction carries no extension words.
    assign hit = insn_valid && (insn_word == BGE_OPCODE); // [RULE_01]

    // Format and vector offset word: vector number times four.
    assign frame_word = {16'h0000, BGE_FRAME_FMT, 2'b00,
                         BGE_ILLEGAL_VEC, 2'b00};

    // All state in r_reg is computed here and registered below; wptr_reg is updated in the clocked block.
    always_comb
    begin
        r_next = r_reg;
        r_next.resume = 1'b0;
        r_next.new_pc_valid = 1'b0;
        case (r_reg.state)
            BGE_IDLE:
            begin
                if (hit)
                begin
                    r_next.busy = 1'b1;
                    r_next.pc = insn_pc;
                    r_next.psw = psw_in; // [RULE_02]
                    r_next.supervisor_stack_pointer = ssp_in;
                    if (bg_enable)
                    begin
                        r_next.state = BGE_BACKGROUND; // [RULE_02]
                        r_next.freeze = 1'b1; // [RULE_03]
                    end
                    else
                    begin
                        r_next.state = BGE_PUSH_FMT;
                        r_next.wr.valid = 1'b1;
                        r_next.wr.long_word = 1'b0;
                        r_next.wr.addr = bge_predec(ssp_in, 1'b0); // [RULE_05]
                        r_next.wr.data = frame_word;
                        r_next.supervisor_stack_pointer = bge_predec(ssp_in, 1'b0);
                    end
                end
            end
            BGE_PUSH_FMT:
            begin
                if (wr_ready)
                begin
                    r_next.state = BGE_PUSH_PC;
                    r_next.wr.long_word = 1'b1;
                    r_next.wr.addr = bge_predec(r_reg.supervisor_stack_pointer, 1'b1); // [RULE_05]
                    r_next.wr.data = r_reg.pc;
                    r_next.supervisor_stack_pointer = bge_predec(r_reg.supervisor_stack_pointer, 1'b1);
                end
            end
            BGE_PUSH_PC:
            begin
                if (wr_ready)
                begin
                    r_next.state = BGE_PUSH_PSW;
                    r_next.wr.long_word = 1'b0;
                    r_next.wr.addr = bge_predec(r_reg.supervisor_stack_pointer, 1'b0); // [RULE_05]
                    r_next.wr.data = {16'h0000, r_reg.psw};
                    r_next.supervisor_stack_pointer = bge_predec(r_reg.supervisor_stack_pointer, 1'b0);
                end
            end
            BGE_PUSH_PSW:
            begin
                if (wr_ready)
                begin
                    r_next.state = BGE_VEC_REQ;
                    r_next.wr.valid = 1'b0;
                    r_next.vec_req = 1'b1;
                    r_next.vec_addr = vbr_in
                        + {22'h00_0000, BGE_ILLEGAL_VEC, 2'b00}; // [RULE_06]
                end
            end
            BGE_VEC_REQ, BGE_VEC_WAIT:
            begin
                r_next.state = BGE_VEC_WAIT;
                if (vec_valid)
                begin
                    // Vector word goes straight into the program counter.
                    r_next.vec_req = 1'b0;
                    r_next.pc = vec_data; // [RULE_06]
                    r_next.new_pc_valid = 1'b1;
                    r_next.busy = 1'b0;
                    r_next.state = BGE_IDLE;
                end
            end
            BGE_BACKGROUND:
            begin
                // The host may have moved the counter, so its value wins.
                if (bg_exit)
                begin
                    r_next.pc = bg_pc_in; // [RULE_04]
                    r_next.new_pc_valid = 1'b1;
                    r_next.resume = 1'b1;
                    r_next.freeze = 1'b0;
                    r_next.busy = 1'b0;
                    r_next.state = BGE_IDLE;
                end
            end
            default:
            begin
                r_next.state = BGE_IDLE;
            end
        endcase
    end

    // Registers r_reg, which holds all control state, and the trace write pointer wptr_reg.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            r_reg <= '{state: BGE_IDLE, pc: BGE_PC_RESET,
                       supervisor_stack_pointer: BGE_SSP_RESET, vec_addr: BGE_VBR_RESET,
                       default: '0};
            wptr_reg <= 4'h0;
        end
        else
        begin
            r_reg <= r_next;
            if (r_reg.wr.valid && wr_ready)
            begin
                wptr_reg <= wptr_reg + 4'h1;
            end
        end
    end

    // Keeps the last pushed frame words for debug read-back.
    bge_stack_mem #(.DEPTH(BGE_STACK_DEPTH), .AW(4)) u_trace (
        .mclk(mclk),
        .we(r_reg.wr.valid && wr_ready),
        .waddr(wptr_reg),
        .wdata(r_reg.wr.data),
        .raddr(trace_raddr),
        .rdata(trace_rdata)
    );

    assign busy = r_reg.busy;
    assign freeze = r_reg.freeze;
    assign resume = r_reg.resume;
    assign new_pc_valid = r_reg.new_pc_valid;
    assign new_pc = r_reg.pc;
    assign ssp_out = r_reg.supervisor_stack_pointer;
    assign psw_out = r_reg.psw;
    assign wr = r_reg.wr;
    assign vec_req = r_reg.vec_req;
    assign vec_addr = r_reg.vec_addr;
endmodule : bge_entry

// ==== rtl/bge_pkg.sv ====
// Functional notes
// [RULE_01] Decode the one-word opcode 0x4AFA as background entry, no extension words.
// [RULE_02] Enabled: halt instruction execution, enter background, condition codes untouched.
// [RULE_03] On background entry raise the freeze output toward the debug host.
// [RULE_04] On leaving background resume at the current program counter value.
// [RULE_05] Disabled: push format word, then PC, then state word, predecrementing stack.
// [RULE_06] Disabled: use illegal-instruction vector number, fetch vector, load into PC.
package bge_pkg;
    localparam logic [15:0] BGE_OPCODE = 16'h4AFA;
    localparam logic [7:0] BGE_ILLEGAL_VEC = 8'h04;
    localparam logic [3:0] BGE_FRAME_FMT = 4'h0;
    localparam logic [31:0] BGE_VBR_RESET = 32'h0000_0000;
    localparam logic [31:0] BGE_SSP_RESET = 32'h0000_0000;
    localparam logic [31:0] BGE_PC_RESET = 32'h0000_0000;
    localparam logic [31:0] BGE_WORD_STEP = 32'h0000_0002;
    localparam logic [31:0] BGE_LONG_STEP = 32'h0000_0004;
    localparam int BGE_STACK_DEPTH = 16;

    typedef enum logic [2:0] {
        BGE_IDLE,
        BGE_PUSH_FMT,
        BGE_PUSH_PC,
        BGE_PUSH_PSW,
        BGE_VEC_REQ,
        BGE_VEC_WAIT,
        BGE_BACKGROUND
    } bge_state_t;

    // Memory write request toward the supervisor stack.
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic long_word;
    } bge_wr_t;

    typedef struct packed {
        bge_state_t state;
        logic [31:0] pc;
        logic [31:0] supervisor_stack_pointer;
        logic [15:0] psw;
        logic freeze;
        logic busy;
        logic resume;
        logic new_pc_valid;
        logic vec_req;
        logic [31:0] vec_addr;
        bge_wr_t wr;
    } bge_regs_t;

    // Step the stack pointer down by one word or long word.
    function automatic logic [31:0] bge_predec(input logic [31:0] sp,
                                               input logic long_word);
        bge_predec = long_word ? sp - BGE_LONG_STEP : sp - BGE_WORD_STEP;
    endfunction : bge_predec
endpackage : bge_pkg

// ==== rtl/bge_stack_mem.sv ====
`timescale 1ns/10ps
// Small on-chip copy of the exception frame words, registered read port.
module bge_stack_mem
    import bge_pkg::*;
#(
    parameter int DEPTH = BGE_STACK_DEPTH,
    parameter int AW = $clog2(DEPTH)
)
(
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem [DEPTH];

    // Read data come out of a register so the path stays one cycle.
    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : bge_stack_mem

// ==== testbench/bge_entry_sva.sv ====
`timescale 1ns/10ps
// Halt, exit and exception frame timing seen at the core's ports.
module bge_entry_sva
    import bge_pkg::*;
(
    input wire logic mclk, srst, insn_valid, bg_enable, bg_exit, busy,
    input wire logic freeze, resume, vec_req, vec_valid, new_pc_valid,
    input wire logic [15:0] insn_word,
    input wire logic [31:0] bg_pc_in, ssp_in, vbr_in, vec_addr,
    input wire logic [31:0] vec_data, new_pc,
    input wire bge_wr_t wr
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // An opcode offered while the core still runs normally.
    sequence s_op;
        !busy && insn_valid;
    endsequence
    property p_dec;
        s_op ##0 insn_word != BGE_OPCODE |=> !busy;
    endproperty
    a_dec: assert property (p_dec) else $error("stray entry");
    property p_enter;
        s_op ##0 insn_word == BGE_OPCODE && bg_enable |=> freeze && busy;
    endproperty
    a_enter: assert property (p_enter) else $error("no freeze");
    property p_hold;
        freeze && !bg_exit |=> freeze && busy && !wr.valid;
    endproperty
    a_hold: assert property (p_hold) else $error("halt lost");
    property p_exit;
        freeze && bg_exit |=> resume && !freeze && new_pc == $past(bg_pc_in);
    endproperty
    a_exit: assert property (p_exit) else $error("bad resume");
    property p_push;
        s_op ##0 insn_word == BGE_OPCODE && !bg_enable |=>
            wr.valid && wr.addr == $past(ssp_in) - BGE_WORD_STEP;
    endproperty
    a_push: assert property (p_push) else $error("bad push");
    property p_fetch;
        vec_req && vec_valid |-> vec_addr == vbr_in + 32'h0000_0010
            ##1 new_pc_valid && new_pc == $past(vec_data);
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad vector");
endmodule : bge_entry_sva
bind bge_entry bge_entry_sva chk (.mclk, .srst, .insn_valid, .bg_enable,
    .bg_exit, .busy, .freeze, .resume, .vec_req, .vec_valid, .new_pc_valid,
    .insn_word, .bg_pc_in, .ssp_in, .vbr_in, .vec_addr, .vec_data, .new_pc,
    .wr);

// ==== testbench/bge_host_model.sv ====
`timescale 1ns/10ps
// Memory side of the core: acknowledges pushes and answers vector fetches.
module bge_host_model
    import bge_pkg::*;
(
    input wire logic mclk, slow, vec_req,
    input wire bge_wr_t wr,
    output logic wr_ready = 1'b0,
    output logic vec_valid = 1'b0,
    output logic [31:0] vec_data = 32'h0000_0000
);
    logic [63:0] log_w [3];
    logic [1:0] n = 2'h0;
    int k = 0;
    // Slow mode stretches each answer; idle data flips so stale reads fail.
    always @(posedge mclk)
    begin
        wr_ready <= 1'b0;
        vec_valid <= 1'b0;
        vec_data <= ~vec_data;
        if (wr.valid && wr_ready)
        begin
            log_w[k % 3] <= {wr.addr, wr.data};
            k <= k + 1;
        end
        if ((wr.valid || vec_req) && !wr_ready && !vec_valid)
        begin
            n <= n + 2'h1;
            if (n >= {slow, 1'b0})
            begin
                n <= 2'h0;
                wr_ready <= wr.valid;
                vec_valid <= !wr.valid;
                vec_data <= 32'h0000_1230;
            end
        end
    end
endmodule : bge_host_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import bge_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, insn_valid = 1'b0, bg_enable = 1'b0;
    logic bg_exit = 1'b0, slow = 1'b0, wr_ready, vec_valid, busy, freeze;
    logic resume, new_pc_valid, vec_req;
    logic [15:0] insn_word = 16'h0000, psw_in = 16'h2704, psw_out;
    logic [31:0] insn_pc = 32'h0000_0400, ssp_in = 32'h0000_1000;
    logic [31:0] vbr_in = 32'h0000_0800, bg_pc_in = 32'h0000_2468;
    logic [31:0] vec_data, new_pc, ssp_out, vec_addr, trace_rdata;
    logic [3:0] trace_raddr = 4'h0;
    bge_wr_t wr;
    int n_mismatch = 0;
    int comparisons = 0;
    bge_entry dut (.mclk, .srst, .insn_valid, .insn_word, .insn_pc, .psw_in,
        .ssp_in, .vbr_in, .bg_enable, .bg_exit, .bg_pc_in, .wr_ready,
        .vec_valid, .vec_data, .trace_raddr, .busy, .freeze, .resume,
        .new_pc_valid, .new_pc, .ssp_out, .psw_out, .wr, .vec_req, .vec_addr,
        .trace_rdata);
    bge_host_model host (.mclk, .slow, .vec_req, .wr, .wr_ready, .vec_valid,
        .vec_data);
    // Core clock; inputs set here move 1 ns after a rising edge, the host model's on the edge.
    initial forever #12.5 mclk = ~mclk;
    task automatic results;
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic check(input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h", $time, seen);
        end
    endtask : check
    task automatic step;
        @(posedge mclk);
        #1;
    endtask : step
    // One opcode offered for a single cycle; an idle edge comes first so
    // that the valid strobe of a previous call is seen low before rising.
    task automatic trig(input logic [15:0] w, input logic en);
        step();
        insn_word = w;
        bg_enable = en;
        insn_valid = 1'b1;
        step();
        insn_valid = 1'b0;
    endtask : trig
    // Halt, a second trigger that must be ignored, then exit.
    task automatic s_enabled;
        trig(BGE_OPCODE, 1'b1);
        check({busy, freeze}, 2'b11);
        trig(BGE_OPCODE, 1'b0);
        check({freeze, wr.valid}, 2'b10);
        check(psw_out, psw_in);
        bg_exit = 1'b1;
        step();
        bg_exit = 1'b0;
        check({resume, freeze, busy, new_pc_valid, new_pc},
            {4'b1001, bg_pc_in});
    endtask : s_enabled
    // Illegal-instruction frame against prompt or slow memory.
    task automatic s_disabled(input logic s);
        slow = s;
        trig(BGE_OPCODE, 1'b0);
        repeat (40)
            if (new_pc_valid !== 1'b1)
                step();
        check(new_pc_valid, 1'b1);
        if (new_pc_valid !== 1'b1)
            results();
        check({busy, new_pc}, 33'h0_0000_1230);
        check(ssp_out, 32'h0000_0FF8);
        check(host.log_w[0], 64'h0000_0FFE_0000_0010);
        check(host.log_w[1], 64'h0000_0FFA_0000_0400);
        check(host.log_w[2], 64'h0000_0FF8_0000_2704);
    endtask : s_disabled
    initial
    begin
        repeat (2) step();
        srst = 1'b0;
        trig(16'h4AFB, 1'b1);
        check(busy, 1'b0);
        s_enabled();
        s_disabled(1'b0);
        // The trace keeps the pushed program counter in its second slot.
        trace_raddr = 4'h1;
        step();
        check(trace_rdata, 32'h0000_0400);
        s_disabled(1'b1);
        results();
    end
endmodule : tb_top
